// file: inc/fnpl_pkg.sv
// Shared constants and types for the fractional-N pattern and lock block
package fnpl_pkg;

  // Field widths of the loaded configuration word, then divisor, accumulator, trim and lock counter widths
  localparam int COUNT_W    = 5;
  localparam int P_SEL_W    = 4;
  localparam int WRAP_SEL_W = 3;
  localparam int POST_SEL_W = 5;
  localparam int DIV_W      = 6;
  localparam int ACC_W      = 6;
  localparam int TRIM_W     = 8;
  localparam int LCNT_W     = 9;

  // Reset values of the latched configuration
  localparam logic [COUNT_W-1:0]    COUNT_RESET    = 5'h00;
  localparam logic [P_SEL_W-1:0]    P_SEL_RESET    = 4'h0;
  localparam logic [WRAP_SEL_W-1:0] WRAP_SEL_RESET = 3'h0;
  localparam logic [POST_SEL_W-1:0] POST_SEL_RESET = 5'h00;

  // Integer divider: P is the select code plus this base
  localparam logic [DIV_W-1:0] P_BASE = 6'h11;

  // Center trim counter, restarted at mid-scale for each acquisition
  localparam logic [TRIM_W-1:0] TRIM_RESET = 8'h80;
  localparam logic [TRIM_W-1:0] TRIM_MAX   = 8'hFF;
  localparam logic [TRIM_W-1:0] TRIM_MIN   = 8'h00;
  localparam int                TRIM_STEP_MV = 12;

  // Lock detector counts
  localparam logic [LCNT_W-1:0] LOCK_QUAL_COUNT  = 9'h100;
  localparam logic [LCNT_W-1:0] UNLOCK_NET_COUNT = 9'h100;

  // Wrapper M and N divisor decode, indexed by select code
  localparam logic [DIV_W-1:0] WRAP_DIV_LUT [8] = '{
    6'h10, 6'h10, 6'h12, 6'h11, 6'h1F, 6'h0E, 6'h20, 6'h0F};

  // Post-divider decode; replace entries to change the mapping
  localparam logic [DIV_W-1:0] POST_DIV_LUT [32] = '{
    6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10,
    6'h12, 6'h14, 6'h16, 6'h18, 6'h1A, 6'h1C, 6'h1E, 6'h20,
    6'h22, 6'h24, 6'h26, 6'h28, 6'h2A, 6'h2C, 6'h2E, 6'h30,
    6'h32, 6'h34, 6'h36, 6'h38, 6'h3A, 6'h3C, 6'h3C, 6'h3C};

  // Lock detector states
  typedef enum logic [1:0] {
    LD_HUNT   = 2'b01,
    LD_LOCKED = 2'b10
  } fnpl_lock_state_t;

endpackage : fnpl_pkg

// file: inc/fnpl_lock_if.sv
// Connection between the top level and one lock detector
`timescale 1ns/1ns
interface fnpl_lock_if;
  logic       clear;
  logic       largeErr;
  logic       locked;

  modport det (input clear, input largeErr, output locked);
  modport ctl (output clear, output largeErr, input locked);
endinterface : fnpl_lock_if

// file: rtl/fnpl_lock_detect.sv
// Digital lock detector for one loop
`timescale 1ns/1ns
module fnpl_lock_detect
  import fnpl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  fnpl_lock_if.det lk
);

  fnpl_lock_state_t    state;
  fnpl_lock_state_t    next_state;
  logic [LCNT_W-1:0]   count;
  logic [LCNT_W-1:0]   next_count;

  // Qualify clean clocks while hunting, net error count once locked
  always_comb begin
    next_state = state;
    next_count = count;
    if (lk.clear) begin
      next_state = LD_HUNT;
      next_count = '0;
    end else begin
      unique case (state)
        LD_HUNT: begin
          if (lk.largeErr) begin
            next_count = '0;
          end else if (count == LOCK_QUAL_COUNT - 9'h001) begin
            next_state = LD_LOCKED;
            next_count = '0;
          end else begin
            next_count = count + 9'h001;
          end
        end
        LD_LOCKED: begin
          if (lk.largeErr) begin
            if (count == UNLOCK_NET_COUNT - 9'h001) begin
              next_state = LD_HUNT;
              next_count = '0;
            end else begin
              next_count = count + 9'h001;
            end
          end else if (count != '0) begin
            next_count = count - 9'h001;
          end
        end
        default: begin
          next_state = LD_HUNT;
          next_count = '0;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= LD_HUNT;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign lk.locked = (state == LD_LOCKED);

endmodule : fnpl_lock_detect

// file: rtl/fnpl_top.sv
// Digital control of the two-loop fractional-N synthesizer
`timescale 1ns/1ns
module fnpl_top
  import fnpl_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  acqStart,
  input  wire logic [COUNT_W-1:0]    highRatioCountField,
  input  wire logic [COUNT_W-1:0]    lowRatioCountField,
  input  wire logic [P_SEL_W-1:0]    integerDivSelect,
  input  wire logic [WRAP_SEL_W-1:0] wrapperDenominatorSelect,
  input  wire logic [WRAP_SEL_W-1:0] wrapperNumeratorSelect,
  input  wire logic [POST_SEL_W-1:0] outputPostDividerSelect,
  input  wire logic                  trimStep,
  input  wire logic                  trimDown,
  input  wire logic                  fracPumpUp,
  input  wire logic                  fracPumpDown,
  input  wire logic                  wrapPumpUp,
  input  wire logic                  wrapPumpDown,
  output logic                       divideSelect,
  output logic [DIV_W-1:0]           feedbackDivisor,
  output logic [DIV_W-1:0]           integerDivisor,
  output logic                       patternWrap,
  output logic [DIV_W-1:0]           wrapperDenominator,
  output logic [DIV_W-1:0]           wrapperNumerator,
  output logic [DIV_W-1:0]           postDivisor,
  output logic                       synthOutputP,
  output logic                       synthOutputN,
  output logic [TRIM_W-1:0]          coarseTrimFrac,
  output logic [TRIM_W-1:0]          coarseTrimWrap,
  output logic                       fracLocked,
  output logic                       wrapLocked,
  output logic                       locked
);

  // Configuration latched when acquisition begins
  logic [COUNT_W-1:0]    highCount;
  logic [COUNT_W-1:0]    next_highCount;
  logic [COUNT_W-1:0]    lowCount;
  logic [COUNT_W-1:0]    next_lowCount;
  logic [P_SEL_W-1:0]    pSel;
  logic [P_SEL_W-1:0]    next_pSel;
  logic [WRAP_SEL_W-1:0] denSel;
  logic [WRAP_SEL_W-1:0] next_denSel;
  logic [WRAP_SEL_W-1:0] numSel;
  logic [WRAP_SEL_W-1:0] next_numSel;
  logic [POST_SEL_W-1:0] postSel;
  logic [POST_SEL_W-1:0] next_postSel;
  logic [DIV_W-1:0]      next_integerDivisor;
  logic [DIV_W-1:0]      next_wrapperDenominator;
  logic [DIV_W-1:0]      next_wrapperNumerator;
  logic [DIV_W-1:0]      next_postDivisor;

  // Fields change only at acquisition so the loops never see a torn word
  always_comb begin
    next_highCount = highCount;
    next_lowCount  = lowCount;
    next_pSel      = pSel;
    next_denSel    = denSel;
    next_numSel    = numSel;
    next_postSel   = postSel;
    if (acqStart) begin
      next_highCount = highRatioCountField;
      next_lowCount  = lowRatioCountField;
      next_pSel      = integerDivSelect;
      next_denSel    = wrapperDenominatorSelect;
      next_numSel    = wrapperNumeratorSelect;
      next_postSel   = outputPostDividerSelect;
    end
    next_integerDivisor     = {2'b00, next_pSel} + P_BASE;
    next_wrapperDenominator = WRAP_DIV_LUT[next_denSel];
    next_wrapperNumerator   = WRAP_DIV_LUT[next_numSel];
    next_postDivisor        = POST_DIV_LUT[next_postSel];
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      highCount          <= COUNT_RESET;
      lowCount           <= COUNT_RESET;
      pSel               <= P_SEL_RESET;
      denSel             <= WRAP_SEL_RESET;
      numSel             <= WRAP_SEL_RESET;
      postSel            <= POST_SEL_RESET;
      integerDivisor     <= P_BASE;
      wrapperDenominator <= WRAP_DIV_LUT[0];
      wrapperNumerator   <= WRAP_DIV_LUT[0];
      postDivisor        <= POST_DIV_LUT[0];
    end else begin
      highCount          <= next_highCount;
      lowCount           <= next_lowCount;
      pSel               <= next_pSel;
      denSel             <= next_denSel;
      numSel             <= next_numSel;
      postSel            <= next_postSel;
      integerDivisor     <= next_integerDivisor;
      wrapperDenominator <= next_wrapperDenominator;
      wrapperNumerator   <= next_wrapperNumerator;
      postDivisor        <= next_postDivisor;
    end
  end

  // Bresenham pattern accumulator
  logic             active;
  logic             next_active;
  logic [ACC_W-1:0] accum;
  logic [ACC_W-1:0] next_accum;
  logic [ACC_W-1:0] patTotal;
  logic [ACC_W-1:0] patSum;
  logic [ACC_W-1:0] patReduced;
  logic             patWrapped;
  logic             next_divideSelect;
  logic             next_patternWrap;
  logic [DIV_W-1:0] next_feedbackDivisor;

  // Accum stays below the total, so the sum fits six bits for totals up to 33; the
  // all-zero count setting is left undefined and just free-runs
  always_comb begin
    patTotal   = {1'b0, highCount} + {1'b0, lowCount};
    patSum     = accum + {1'b0, lowCount};
    patWrapped = (patSum >= patTotal);
    patReduced = patWrapped ? patSum - patTotal : patSum;
    next_active       = active | acqStart;
    next_accum        = accum;
    next_divideSelect = 1'b1;
    next_patternWrap  = 1'b0;
    if (acqStart) begin
      next_accum = '0;
    end else if (active) begin
      next_accum        = patReduced;
      next_divideSelect = ~patWrapped;
      next_patternWrap  = (patReduced == '0);
    end
    // Select one picks P, zero picks P minus one
    next_feedbackDivisor = next_divideSelect ? next_integerDivisor
                         : next_integerDivisor - 6'h01;
  end

  // Pattern registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active          <= 1'b0;
      accum           <= '0;
      divideSelect    <= 1'b1;
      patternWrap     <= 1'b0;
      feedbackDivisor <= P_BASE;
    end else begin
      active          <= next_active;
      accum           <= next_accum;
      divideSelect    <= next_divideSelect;
      patternWrap     <= next_patternWrap;
      feedbackDivisor <= next_feedbackDivisor;
    end
  end

  // Post divider: a one-cycle high per period, duty cycle not kept
  logic [DIV_W-1:0] postCnt;
  logic [DIV_W-1:0] next_postCnt;
  logic             next_synthOutputP;

  always_comb begin
    next_postCnt      = postCnt + 6'h01;
    next_synthOutputP = 1'b0;
    if (acqStart) begin
      next_postCnt = '0;
    end else if (postCnt >= postDivisor - 6'h01) begin
      next_postCnt      = '0;
      next_synthOutputP = 1'b1;
    end
  end

  // Post divider registers; both legs from flops to keep them aligned
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      postCnt      <= '0;
      synthOutputP <= 1'b0;
      synthOutputN <= 1'b1;
    end else begin
      postCnt      <= next_postCnt;
      synthOutputP <= next_synthOutputP;
      synthOutputN <= ~next_synthOutputP;
    end
  end

  // Center frequency trim, shared by both oscillators
  logic [TRIM_W-1:0] trim;
  logic [TRIM_W-1:0] next_trim;

  // Saturate at the ends so a runaway sequencer cannot wrap the VCO
  always_comb begin
    next_trim = trim;
    if (acqStart) begin
      next_trim = TRIM_RESET;
    end else if (trimStep) begin
      if (trimDown) begin
        if (trim != TRIM_MIN) next_trim = trim - 8'h01;
      end else begin
        if (trim != TRIM_MAX) next_trim = trim + 8'h01;
      end
    end
  end

  // Trim register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim <= TRIM_RESET;
    end else begin
      trim <= next_trim;
    end
  end

  // One counter drives both coarse inputs identically
  assign coarseTrimFrac = trim;
  assign coarseTrimWrap = trim;

  // Pump pulses come from the analog side: two flops before use
  logic [3:0] pumpMeta;
  logic [3:0] next_pumpMeta;
  logic [3:0] pumpSync;
  logic [3:0] next_pumpSync;

  always_comb begin
    next_pumpMeta = {wrapPumpDown, wrapPumpUp, fracPumpDown, fracPumpUp};
    next_pumpSync = pumpMeta;
  end

  // Synchroniser registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pumpMeta <= 4'h0;
      pumpSync <= 4'h0;
    end else begin
      pumpMeta <= next_pumpMeta;
      pumpSync <= next_pumpSync;
    end
  end

  // Lock detectors, one per loop
  fnpl_lock_if fracLk ();
  fnpl_lock_if wrapLk ();

  // Pulse still present at the reference edge counts as a large error
  assign fracLk.largeErr = pumpSync[0] | pumpSync[1];
  assign wrapLk.largeErr = pumpSync[2] | pumpSync[3];
  assign fracLk.clear    = acqStart;
  assign wrapLk.clear    = acqStart;

  fnpl_lock_detect uFracLock (
    .mclk  (mclk),
    .rst_n (rst_n),
    .lk    (fracLk.det)
  );

  fnpl_lock_detect uWrapLock (
    .mclk  (mclk),
    .rst_n (rst_n),
    .lk    (wrapLk.det)
  );

  logic next_locked;

  always_comb begin
    next_locked = fracLk.locked & wrapLk.locked;
  end

  // Lock status registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fracLocked <= 1'b0;
      wrapLocked <= 1'b0;
      locked     <= 1'b0;
    end else begin
      fracLocked <= fracLk.locked;
      wrapLocked <= wrapLk.locked;
      locked     <= next_locked;
    end
  end

endmodule : fnpl_top

// file: dv/fnpl_top_monitor.sv
// Concurrent checks on the synthesizer control top
`timescale 1ns/1ns
module fnpl_top_monitor
  import fnpl_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  acqStart,
  input wire logic [P_SEL_W-1:0]    integerDivSelect,
  input wire logic                  trimStep,
  input wire logic                  trimDown,
  input wire logic                  fracPumpUp,
  input wire logic                  fracPumpDown,
  input wire logic                  divideSelect,
  input wire logic [DIV_W-1:0]      feedbackDivisor,
  input wire logic [DIV_W-1:0]      integerDivisor,
  input wire logic                  patternWrap,
  input wire logic                  synthOutputP,
  input wire logic                  synthOutputN,
  input wire logic [TRIM_W-1:0]     coarseTrimFrac,
  input wire logic [TRIM_W-1:0]     coarseTrimWrap,
  input wire logic                  fracLocked,
  input wire logic                  wrapLocked,
  input wire logic                  locked
);
  logic [8:0] fracQuiet;
  logic [8:0] next_fracQuiet;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Quiet run at the pins; saturates so it never wraps back to a low count
  always_comb begin
    next_fracQuiet = fracQuiet;
    if (fracPumpUp || fracPumpDown) next_fracQuiet = 9'h000;
    else if (fracQuiet != 9'h1FF) next_fracQuiet = fracQuiet + 9'h001;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) fracQuiet <= 9'h000;
    else fracQuiet <= next_fracQuiet;
  end

  sequence lockCleared;
    !fracLocked && !wrapLocked && !locked;
  endsequence
  sequence patternIdle;
    divideSelect && !patternWrap;
  endsequence

  chk_lock_both: assert property (
    locked == (fracLocked && wrapLocked)) else $error("lock output mismatch");
  chk_fb_divisor: assert property (
    feedbackDivisor == (divideSelect ? integerDivisor
                                     : integerDivisor - 6'h01))
    else $error("feedback divisor mismatch");
  chk_int_decode: assert property (
    acqStart |=> integerDivisor == $past(integerDivSelect) + 6'h11)
    else $error("integer divisor decode wrong");
  chk_pattern_start: assert property (
    acqStart |=> patternIdle) else $error("pattern not restarted");
  chk_out_pair: assert property (
    synthOutputN == !synthOutputP) else $error("output pair not inverse");
  chk_trim_same: assert property (
    coarseTrimFrac == coarseTrimWrap) else $error("trim outputs differ");
  chk_trim_up: assert property (
    trimStep && !trimDown && !acqStart && coarseTrimFrac != 8'hFF
    |=> coarseTrimFrac == $past(coarseTrimFrac) + 8'h01)
    else $error("trim up step wrong");
  chk_trim_down: assert property (
    trimStep && trimDown && !acqStart && coarseTrimFrac != 8'h00
    |=> coarseTrimFrac == $past(coarseTrimFrac) - 8'h01)
    else $error("trim down step wrong");
  chk_acq_clear: assert property (
    acqStart |-> ##2 lockCleared) else $error("lock not cleared");
  chk_hunt_run: assert property (
    $rose(fracLocked) |-> fracQuiet >= 9'h101)
    else $error("lock declared too early");
endmodule : fnpl_top_monitor

bind fnpl_top fnpl_top_monitor i_fnpl_top_monitor (
  .mclk(mclk), .rst_n(rst_n), .acqStart(acqStart),
  .integerDivSelect(integerDivSelect), .trimStep(trimStep),
  .trimDown(trimDown), .fracPumpUp(fracPumpUp), .fracPumpDown(fracPumpDown),
  .divideSelect(divideSelect), .feedbackDivisor(feedbackDivisor),
  .integerDivisor(integerDivisor), .patternWrap(patternWrap),
  .synthOutputP(synthOutputP), .synthOutputN(synthOutputN),
  .coarseTrimFrac(coarseTrimFrac), .coarseTrimWrap(coarseTrimWrap),
  .fracLocked(fracLocked), .wrapLocked(wrapLocked), .locked(locked));

// file: dv/fnpl_cfg_host.sv
// Microcontroller model that loads the 32-bit configuration word
`timescale 1ns/1ns
module fnpl_cfg_host
  import fnpl_pkg::*;
(
  input  wire logic                  mclk,
  output logic                       acqStart,
  output logic [COUNT_W-1:0]         highRatioCountField,
  output logic [COUNT_W-1:0]         lowRatioCountField,
  output logic [P_SEL_W-1:0]         integerDivSelect,
  output logic [WRAP_SEL_W-1:0]      wrapperDenominatorSelect,
  output logic [WRAP_SEL_W-1:0]      wrapperNumeratorSelect,
  output logic [POST_SEL_W-1:0]      outputPostDividerSelect
);
  // Idle values at time zero
  initial begin
    acqStart = 1'b0;
    {highRatioCountField, lowRatioCountField, integerDivSelect} = 14'h0000;
    {outputPostDividerSelect, wrapperNumeratorSelect} = 8'h00;
    wrapperDenominatorSelect = 3'h0;
  end

  // Fields in load order: fill, high, low, P code, fill, post, N, M
  task automatic load(input logic [31:0] word);
    @(posedge mclk);
    #1;
    {highRatioCountField, lowRatioCountField, integerDivSelect} =
      word[27:14];
    outputPostDividerSelect = word[10:6];
    wrapperNumeratorSelect = word[5:3];
    wrapperDenominatorSelect = word[2:0];
    acqStart = 1'b1;
    @(posedge mclk);
    #1;
    acqStart = 1'b0;
    // Fields scrambled once taken, so a late sample shows up
    {highRatioCountField, lowRatioCountField, integerDivSelect} =
      ~word[27:14];
    outputPostDividerSelect = ~word[10:6];
    {wrapperNumeratorSelect, wrapperDenominatorSelect} = ~word[5:0];
  endtask : load
endmodule : fnpl_cfg_host

// file: dv/fnpl_top_tb_top.sv
// Self-checking bench for the synthesizer control top
`timescale 1ns/1ns
module fnpl_top_tb_top
  import fnpl_pkg::*;
;
  logic                  mclk, rst_n, acqStart, trimStep, trimDown;
  logic                  fracPumpUp, fracPumpDown, wrapPumpUp, wrapPumpDown;
  logic [COUNT_W-1:0]    highRatioCountField, lowRatioCountField;
  logic [P_SEL_W-1:0]    integerDivSelect;
  logic [WRAP_SEL_W-1:0] wrapperDenominatorSelect, wrapperNumeratorSelect;
  logic [POST_SEL_W-1:0] outputPostDividerSelect;
  logic                  divideSelect, patternWrap, synthOutputP, synthOutputN;
  logic                  fracLocked, wrapLocked, locked;
  logic [DIV_W-1:0]      feedbackDivisor, integerDivisor, postDivisor;
  logic [DIV_W-1:0]      wrapperDenominator, wrapperNumerator;
  logic [TRIM_W-1:0]     coarseTrimFrac, coarseTrimWrap;
  int                    errCount, nTests, n, acc, sum, tot;
  logic [4:0]            hi, lo, pc;
  logic                  b;
  logic [7:0]            pdiv;
  // Legal pairs: each count and the sum stay within 31, never both zero
  logic [4:0] hiT [8] = '{5'h12, 5'h02, 5'h00, 5'h09,
                          5'h1A, 5'h01, 5'h0F, 5'h03};
  logic [4:0] loT [8] = '{5'h05, 5'h01, 5'h07, 5'h00,
                          5'h05, 5'h1E, 5'h0F, 5'h04};
  logic [4:0] pcT [8] = '{5'h00, 5'h1F, 5'h05, 5'h1D,
                          5'h1E, 5'h01, 5'h0C, 5'h14};
  logic [5:0] wrapT [8] = '{6'h10, 6'h10, 6'h12, 6'h11,
                            6'h1F, 6'h0E, 6'h20, 6'h0F};

  fnpl_top i_fnpl_top (.mclk(mclk), .rst_n(rst_n), .acqStart(acqStart),
    .highRatioCountField(highRatioCountField),
    .lowRatioCountField(lowRatioCountField),
    .integerDivSelect(integerDivSelect),
    .wrapperDenominatorSelect(wrapperDenominatorSelect),
    .wrapperNumeratorSelect(wrapperNumeratorSelect),
    .outputPostDividerSelect(outputPostDividerSelect),
    .trimStep(trimStep), .trimDown(trimDown), .fracPumpUp(fracPumpUp),
    .fracPumpDown(fracPumpDown), .wrapPumpUp(wrapPumpUp),
    .wrapPumpDown(wrapPumpDown), .divideSelect(divideSelect),
    .feedbackDivisor(feedbackDivisor), .integerDivisor(integerDivisor),
    .patternWrap(patternWrap), .wrapperDenominator(wrapperDenominator),
    .wrapperNumerator(wrapperNumerator), .postDivisor(postDivisor),
    .synthOutputP(synthOutputP), .synthOutputN(synthOutputN),
    .coarseTrimFrac(coarseTrimFrac), .coarseTrimWrap(coarseTrimWrap),
    .fracLocked(fracLocked), .wrapLocked(wrapLocked), .locked(locked));

  fnpl_cfg_host i_fnpl_cfg_host (.mclk(mclk), .acqStart(acqStart),
    .highRatioCountField(highRatioCountField),
    .lowRatioCountField(lowRatioCountField),
    .integerDivSelect(integerDivSelect),
    .wrapperDenominatorSelect(wrapperDenominatorSelect),
    .wrapperNumeratorSelect(wrapperNumeratorSelect),
    .outputPostDividerSelect(outputPostDividerSelect));

  // Reference clock, 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Bounded wait on frac lock (0), wrap lock (1) or output pulse (2)
  task automatic waitFor(input int sel, input logic val, input int lim);
    logic s;
    n = 0;
    do begin
      tick(1);
      n++;
      s = (sel == 0) ? fracLocked : (sel == 1) ? wrapLocked : synthOutputP;
    end while (s !== val && n < lim);
    if (s !== val) begin
      errCount++;
      $display("[ERR] %0t wait timed out", $time);
      end_of_test();
    end
  endtask : waitFor

  initial begin
    errCount = 0;
    nTests = 0;
    rst_n = 1'b0;
    {trimStep, trimDown, fracPumpUp, fracPumpDown} = 4'h0;
    {wrapPumpUp, wrapPumpDown} = 2'h0;
    tick(16);
    rst_n = 1'b1;
    chk(divideSelect, 8'h01, "idle select");
    chk(integerDivisor, 8'h11, "reset P");
    chk(wrapperNumerator, 8'h10, "reset N");
    chk(postDivisor, 8'h02, "reset post");
    chk(coarseTrimFrac, 8'h80, "reset trim");
    $display("test reset done");
    // Every wrapper code, with N equal to M so the ratio stays legal
    for (int i = 0; i < 8; i++) begin
      hi = hiT[i];
      lo = loT[i];
      pc = pcT[i];
      tot = hi + lo;
      pdiv = (pc < 30) ? 8'(2 * (pc + 1)) : 8'h3C;
      i_fnpl_cfg_host.load({4'h0, hi, lo, 4'(2 * i + i / 7), 3'h0, pc,
                            3'(i), 3'(i)});
      chk(integerDivisor, 8'(17 + 2 * i + i / 7), "P");
      chk(wrapperDenominator, wrapT[i], "M");
      chk(wrapperNumerator, wrapT[i], "N");
      chk(postDivisor, pdiv, "post");
      acc = 0;
      for (int s = 0; s < 2 * tot; s++) begin
        tick(1);
        sum = acc + lo;
        b = (sum < tot);
        acc = b ? sum : sum - tot;
        chk(divideSelect, 8'(b), "pattern bit");
        if (lo != 0) chk(patternWrap, 8'(acc == 0), "wrap");
      end
      chk(integerDivisor, 8'(17 + 2 * i + i / 7), "P held");
      waitFor(2, 1'b1, 70);
      waitFor(2, 1'b1, 70);
      chk(8'(n), pdiv, "post period");
    end
    $display("test pattern done");
    trimStep = 1'b1;
    tick(1);
    chk(coarseTrimFrac, 8'h81, "trim up");
    tick(129);
    chk(coarseTrimFrac, 8'hFF, "trim top");
    trimDown = 1'b1;
    tick(1);
    chk(coarseTrimFrac, 8'hFE, "trim down");
    tick(255);
    chk(coarseTrimFrac, 8'h00, "trim bottom");
    i_fnpl_cfg_host.load(32'h0914C000);
    chk(coarseTrimFrac, 8'h80, "trim restart");
    trimStep = 1'b0;
    $display("test trim done");
    // Up pulse late in the hunt, then a down pulse; each restarts the count
    tick(200);
    fracPumpUp = 1'b1;
    tick(1);
    fracPumpUp = 1'b0;
    tick(100);
    chk(wrapLocked, 8'h01, "wrap locked");
    chk(locked, 8'h00, "one loop only");
    fracPumpDown = 1'b1;
    tick(1);
    fracPumpDown = 1'b0;
    waitFor(0, 1'b1, 300);
    chk(8'(n >= 256 && n <= 262), 8'h01, "relock");
    chk(locked, 8'h01, "both locked");
    // Net count: 100 large, 50 small, so loss comes 50 events early
    wrapPumpUp = 1'b1;
    tick(100);
    wrapPumpUp = 1'b0;
    tick(50);
    chk(wrapLocked, 8'h01, "still locked");
    wrapPumpDown = 1'b1;
    waitFor(1, 1'b0, 300);
    chk(8'(n >= 206 && n <= 212), 8'h01, "unlock span");
    chk(locked, 8'h00, "lock dropped");
    wrapPumpDown = 1'b0;
    $display("test lock done");
    end_of_test();
  end
endmodule : fnpl_top_tb_top
